// File: verilog/pwb_pkg.sv
// Shared constants for the two-wire port PWM/blink slave and its master.
// Assumes a single 20 MHz system clock on both ends.
package pwb_pkg;
   // Clock and timebase rates, in Hz
   localparam int CLK_HZ = 20_000_000;
   localparam int INT_TB_HZ = 32_768;
   localparam int SCL_HZ = 100_000;
   // Cycle counts derived from the rates (rounded down)
   localparam int INT_TB_DIV = CLK_HZ / INT_TB_HZ;
   localparam int SCL_QTR = CLK_HZ / (4 * SCL_HZ);
   localparam logic [9:0] INT_DIV_LAST = 10'(INT_TB_DIV - 1);
   localparam logic [5:0] QTR_LAST = 6'(SCL_QTR - 1);

   // Slave address: five fixed bits, two low bits from strap or fixed
   localparam logic [4:0] FIXED_ADDRESS_BITS = 5'h13;
   localparam logic [1:0] FIXED_ADDRESS_LOW = 2'h0;

   // Device register map
   localparam int NUM_PORTS = 4;
   localparam logic [7:0] REG_CFG = 8'h66;
   localparam logic [7:0] REG_PORT0 = 8'h10;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] PORT_RST = 8'h00;
   // Port output level fields
   localparam int PL_OFF = 7;
   localparam int PL_HIGH = 6;
   localparam int PL_BLINK = 5;
   localparam int PL_SEL4 = 4;
   // Blink rate field in the configuration register
   localparam int CFG_BLINK_LSB = 2;
   localparam logic [2:0] BLINK_FAST_CODE = 3'h7;
   localparam logic [4:0] BLINK_TOP_SHIFT = 5'hE;
   localparam logic [4:0] BLINK_FAST_SHIFT = 5'h6;
   localparam int TB_CNT_W = 18;

   // Master command registers
   localparam logic [2:0] H_CTRL = 3'h0;
   localparam logic [2:0] H_SADDR = 3'h1;
   localparam logic [2:0] H_PTR = 3'h2;
   localparam logic [2:0] H_WDATA = 3'h3;
   localparam logic [2:0] H_RDATA = 3'h4;
   localparam logic [2:0] H_STAT = 3'h5;
   localparam int C_GO = 0;
   localparam int C_READ = 1;
   localparam int C_DATA = 2;
   localparam int S_BUSY = 0;
   localparam int S_NACK = 1;
endpackage : pwb_pkg

// File: verilog/pwb_if.sv
// Two-wire bus between the master end and the slave end.
// Open-drain data line resolved here with an implied pull-up.
`timescale 1ns/1ps
interface pwb_if;
   logic scl;
   logic sda_mst_o;
   logic sda_mst_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic sda;

   // Wired-AND of both drivers, high when nobody pulls low
   assign sda = ~((sda_mst_oe & ~sda_mst_o) | (sda_dev_oe & ~sda_dev_o));

   modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
   modport mst (output scl, output sda_mst_o, output sda_mst_oe,
      input sda);
endinterface : pwb_if

// File: verilog/pwb_port_drv.sv
// One port output: static, PWM or blink from its level register.
// Assumes phases advance on the shared timebase counter.
`timescale 1ns/1ps
module pwb_port_drv
   import pwb_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [7:0] level,
   input wire logic [4:0] pwm_phase,
   input wire logic [3:0] blink_phase,
   output logic out_q
);
   // Mode decode; undocumented codes fall back to low
   wire is_high = ~level[PL_OFF] & level[PL_HIGH] & level[PL_BLINK]
      & level[PL_SEL4];
   wire is_pwm = ~level[PL_OFF] & ~level[PL_BLINK];
   wire is_blink = ~level[PL_OFF] & level[PL_BLINK] & ~level[PL_SEL4];
   wire pwm_on = pwm_phase < level[4:0];
   wire blink_on = blink_phase < level[3:0];
   wire next_out = is_high | (is_pwm & pwm_on) | (is_blink & blink_on);

   // Registered so the pin never glitches on a decode change
   always_ff @(posedge clk) begin
      if (!nrst) begin
         out_q <= 1'b0;
      end else if (ce) begin
         out_q <= next_out;
      end
   end
endmodule : pwb_port_drv

// File: verilog/pwb_device.sv
// Slave end: two-wire register access plus per-port PWM/blink outputs.
// Assumes the bus pins are asynchronous to clk and are synchronised here;
// the external timebase is far slower than clk.
//
// Chosen here: the strapped address variant (STRAP_VARIANT defaults to 1).
`timescale 1ns/1ps
module pwb_device
   import pwb_pkg::*;
#(
   parameter bit STRAP_VARIANT = 1'b1
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic ext_timebase_sel,
   input wire logic external_timebase_input,
   input wire logic [1:0] address_strap_input,
   pwb_if.dev bus,
   output logic [NUM_PORTS-1:0] port_out
);
   typedef enum logic [6:0] {
      D_IDLE = 7'h01,
      D_ADDR = 7'h02,
      D_ACK = 7'h04,
      D_WR = 7'h08,
      D_RD = 7'h10,
      D_MACK = 7'h20,
      D_SKIP = 7'h40
   } pwb_dstate_e;

   pwb_dstate_e st;
   logic [2:0] scl_sy;
   logic [2:0] sda_sy;
   logic [2:0] ext_sy;
   logic [3:0] cnt;
   logic [7:0] shreg;
   logic [7:0] tx;
   logic rw;
   logic first;
   logic [7:0] ptr;
   logic sda_oe;
   logic [7:0] cfg;
   logic [7:0] port_lvl [NUM_PORTS];
   logic [1:0] strap_q;
   logic strap_done;
   logic [9:0] int_div;
   logic [TB_CNT_W-1:0] tb_cnt;

   // Synchronised pin levels; stage 0 only feeds stage 1
   wire scl_s = scl_sy[1];
   wire scl_d = scl_sy[2];
   wire sda_s = sda_sy[1];
   wire sda_d = sda_sy[2];
   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   // Data edges with the clock high on both samples
   wire start_c = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_c = scl_s & scl_d & ~sda_d & sda_s;

   // Own address from strap or fixed low bits
   wire [1:0] low_bits = STRAP_VARIANT ? strap_q : FIXED_ADDRESS_LOW;
   wire [6:0] my_addr = {FIXED_ADDRESS_BITS, low_bits};
   wire addr_hit = shreg[7:1] == my_addr;

   // Register decode at the pointer
   wire [7:0] port_off = ptr - REG_PORT0;
   wire is_port = port_off[7:2] == 6'h00;
   wire is_cfg = ptr == REG_CFG;
   wire [7:0] rd_byte = is_port ? port_lvl[port_off[1:0]] :
      (is_cfg ? cfg : 8'h00);
   wire [7:0] next_ptr = ptr + 8'h01;

   // Data line is only ever pulled low; clock never driven
   assign bus.sda_dev_o = 1'b0;
   assign bus.sda_dev_oe = sda_oe;

   // Pin synchronisers, including the external timebase
   always_ff @(posedge clk) begin
      if (!nrst) begin
         scl_sy <= 3'h7;
         sda_sy <= 3'h7;
         ext_sy <= 3'h0;
      end else if (ce) begin
         scl_sy <= {scl_sy[1:0], bus.scl};
         sda_sy <= {sda_sy[1:0], bus.sda};
         ext_sy <= {ext_sy[1:0], external_timebase_input};
      end
   end

   // Strap sampled once after reset release, never under reset
   always_ff @(posedge clk) begin
      if (!nrst) begin
         strap_done <= 1'b0;
         strap_q <= 2'h0;
      end else if (ce && !strap_done) begin
         strap_done <= 1'b1;
         strap_q <= address_strap_input;
      end
   end

   // Bus engine: bits taken on clock rise, data changed on clock fall
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st <= D_IDLE;
         cnt <= 4'h0;
         shreg <= 8'h00;
         tx <= 8'h00;
         rw <= 1'b0;
         first <= 1'b0;
         ptr <= 8'h00;
         sda_oe <= 1'b0;
         cfg <= CFG_RST;
         for (int i = 0; i < NUM_PORTS; i++) begin
            port_lvl[i] <= PORT_RST;
         end
      end else if (ce) begin
         if (start_c) begin
            // Repeated start also lands here and restarts decode
            st <= D_ADDR;
            cnt <= 4'h0;
            sda_oe <= 1'b0;
            first <= 1'b1;
         end else if (stop_c) begin
            st <= D_IDLE;
            sda_oe <= 1'b0;
         end else begin
            case (st)
               D_ADDR, D_WR: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda_s};
                     cnt <= cnt + 4'h1;
                  end else if (scl_fall && cnt == 4'h8) begin
                     cnt <= 4'h0;
                     if (st == D_ADDR) begin
                        if (addr_hit) begin
                           st <= D_ACK;
                           sda_oe <= 1'b1;
                           rw <= shreg[0];
                        end else begin
                           st <= D_SKIP;
                        end
                     end else begin
                        st <= D_ACK;
                        sda_oe <= 1'b1;
                        first <= 1'b0;
                        if (first) begin
                           ptr <= shreg;
                        end else begin
                           if (is_port) begin
                              port_lvl[port_off[1:0]] <= shreg;
                           end
                           if (is_cfg) begin
                              cfg <= shreg;
                           end
                           ptr <= next_ptr;
                        end
                     end
                  end
               end
               D_ACK, D_MACK: begin
                  if (st == D_MACK && scl_rise && sda_s) begin
                     // Master declined more data
                     st <= D_SKIP;
                  end else if (scl_fall) begin
                     cnt <= 4'h0;
                     if (rw) begin
                        st <= D_RD;
                        tx <= {rd_byte[6:0], 1'b0};
                        sda_oe <= ~rd_byte[7];
                        ptr <= next_ptr;
                     end else begin
                        st <= D_WR;
                        sda_oe <= 1'b0;
                     end
                  end
               end
               D_RD: begin
                  if (scl_rise) begin
                     cnt <= cnt + 4'h1;
                  end else if (scl_fall) begin
                     if (cnt == 4'h8) begin
                        st <= D_MACK;
                        sda_oe <= 1'b0;
                     end else begin
                        sda_oe <= ~tx[7];
                        tx <= {tx[6:0], 1'b0};
                     end
                  end
               end
               D_IDLE, D_SKIP: begin
                  sda_oe <= 1'b0;
               end
               default: begin
                  st <= D_IDLE;
               end
            endcase
         end
      end
   end

   // Timebase tick: internal divider or external rising edge
   wire int_wrap = int_div == INT_DIV_LAST;
   wire ext_rise = ext_sy[1] & ~ext_sy[2];
   wire tb_tick = ext_timebase_sel ? ext_rise : int_wrap;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         int_div <= 10'h000;
         tb_cnt <= '0;
      end else if (ce) begin
         int_div <= int_wrap ? 10'h000 : int_div + 10'h001;
         if (tb_tick) begin
            tb_cnt <= tb_cnt + 18'h00001;
         end
      end
   end

   // Blink phase: top four bits of a 2^(18-code) window, 2^10 at code 7
   wire [2:0] blink_code = cfg[CFG_BLINK_LSB +: 3];
   wire [4:0] blink_shift = (blink_code == BLINK_FAST_CODE) ?
      BLINK_FAST_SHIFT : BLINK_TOP_SHIFT - {2'h0, blink_code};
   wire [TB_CNT_W-1:0] tb_shifted = tb_cnt >> blink_shift;
   wire [3:0] blink_phase = tb_shifted[3:0];
   // One PWM step per timebase tick, 32 ticks per period
   wire [4:0] pwm_phase = tb_cnt[4:0];

   // One output generator per port
   for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
      pwb_port_drv u_drv (
         .clk(clk),
         .nrst(nrst),
         .ce(ce),
         .level(port_lvl[g]),
         .pwm_phase(pwm_phase),
         .blink_phase(blink_phase),
         .out_q(port_out[g])
      );
   end
endmodule : pwb_device

// File: verilog/pwb_host.sv
// Master end: drives the clock and runs one command per go request.
// Assumes software uses the plain strobe port on the same clock.
`timescale 1ns/1ps
module pwb_host
   import pwb_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   pwb_if.mst bus
);
   typedef enum logic [3:0] {
      M_IDLE = 4'h1,
      M_START = 4'h2,
      M_BIT = 4'h4,
      M_STOP = 4'h8
   } pwb_mstate_e;

   pwb_mstate_e st;
   logic [1:0] sda_sy;
   logic [5:0] qc;
   logic [1:0] q;
   logic [6:0] saddr;
   logic [7:0] ptr;
   logic [7:0] wdat;
   logic [7:0] rdat;
   logic op_rd;
   logic op_dat;
   logic nack;
   logic [1:0] bi;
   logic [3:0] bc;
   logic [8:0] tx;
   logic [8:0] rx;
   logic scl_q;
   logic oe_q;

   assign bus.scl = scl_q;
   assign bus.sda_mst_o = 1'b0;
   assign bus.sda_mst_oe = oe_q;

   // Frame per byte slot; reads release all nine bits (final nack)
   function automatic logic [8:0] frame(input logic [1:0] i);
      case (i)
         2'h0: frame = {saddr, op_rd, 1'b1};
         2'h1: frame = op_rd ? 9'h1FF : {ptr, 1'b1};
         default: frame = {wdat, 1'b1};
      endcase
   endfunction : frame

   wire busy = st != M_IDLE;
   wire qtick = qc == QTR_LAST;
   wire [1:0] last_bi = (!op_rd && op_dat) ? 2'h2 : 2'h1;
   wire ack_due = (bi == 2'h0) || !op_rd;
   wire go = wr && addr == H_CTRL && wdata[C_GO] && !busy;
   wire [7:0] rmux = (addr == H_SADDR) ? {1'b0, saddr} :
      (addr == H_PTR) ? ptr : (addr == H_WDATA) ? wdat :
      (addr == H_RDATA) ? rdat :
      (addr == H_STAT) ? {6'h00, nack, busy} :
      (addr == H_CTRL) ? {5'h00, op_dat, op_rd, 1'b0} : 8'h00;

   // Command registers and bit sequencer, four quarters per bit
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st <= M_IDLE;
         sda_sy <= 2'h3;
         qc <= 6'h00;
         q <= 2'h0;
         saddr <= 7'h00;
         ptr <= 8'h00;
         wdat <= 8'h00;
         rdat <= 8'h00;
         rdata <= 8'h00;
         op_rd <= 1'b0;
         op_dat <= 1'b0;
         nack <= 1'b0;
         bi <= 2'h0;
         bc <= 4'h0;
         tx <= 9'h1FF;
         rx <= 9'h000;
         scl_q <= 1'b1;
         oe_q <= 1'b0;
      end else if (ce) begin
         sda_sy <= {sda_sy[0], bus.sda};
         rdata <= rd ? rmux : 8'h00;
         if (wr && !busy) begin
            if (addr == H_SADDR) saddr <= wdata[6:0];
            if (addr == H_PTR) ptr <= wdata;
            if (addr == H_WDATA) wdat <= wdata;
         end
         if (wr && addr == H_STAT && wdata[S_NACK]) begin
            nack <= 1'b0;
         end
         if (go) begin
            st <= M_START;
            op_rd <= wdata[C_READ];
            op_dat <= wdata[C_DATA];
            qc <= 6'h00;
            q <= 2'h0;
         end else if (busy) begin
            qc <= qtick ? 6'h00 : qc + 6'h01;
         end
         if (busy && qtick) begin
            q <= q + 2'h1;
            case (st)
               M_START: begin
                  // Data falls while clock high
                  if (q == 2'h1) oe_q <= 1'b1;
                  if (q == 2'h2) scl_q <= 1'b0;
                  if (q == 2'h3) begin
                     st <= M_BIT;
                     bi <= 2'h0;
                     bc <= 4'h0;
                     tx <= frame(2'h0);
                  end
               end
               M_BIT: begin
                  // Data changes only with the clock low
                  if (q == 2'h0) oe_q <= ~tx[8];
                  if (q == 2'h1) scl_q <= 1'b1;
                  if (q == 2'h2) rx <= {rx[7:0], sda_sy[1]};
                  if (q == 2'h3) begin
                     scl_q <= 1'b0;
                     tx <= {tx[7:0], 1'b1};
                     bc <= bc + 4'h1;
                     if (bc == 4'h8) begin
                        bc <= 4'h0;
                        if (ack_due && rx[0]) begin
                           nack <= 1'b1;
                           st <= M_STOP;
                        end else if (bi == last_bi) begin
                           if (op_rd) rdat <= rx[8:1];
                           st <= M_STOP;
                        end else begin
                           bi <= bi + 2'h1;
                           tx <= frame(bi + 2'h1);
                        end
                     end
                  end
               end
               M_STOP: begin
                  // Data rises while clock high
                  if (q == 2'h0) oe_q <= 1'b1;
                  if (q == 2'h1) scl_q <= 1'b1;
                  if (q == 2'h2) oe_q <= 1'b0;
                  if (q == 2'h3) st <= M_IDLE;
               end
               default: begin
                  st <= M_IDLE;
               end
            endcase
         end
      end
   end
endmodule : pwb_host

// File: verification/pwb_checker.sv
// Bus checker for the two-wire link between the master and slave ends.
// Assumes it sits beside the interface and sees the strap value too.
`timescale 1ns/1ps
module pwb_checker
   import pwb_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_mst_o,
   input wire logic sda_mst_oe,
   input wire logic sda_dev_o,
   input wire logic sda_dev_oe,
   input wire logic [1:0] address_strap_input
);
   logic prev_scl;
   logic prev_sda;
   logic in_frame;
   logic [3:0] idx;
   logic [1:0] byte_n;
   logic [7:0] addr_q;
   logic [7:0] lo_cnt;

   // Edge and condition decode from the previous samples
   wire scl_rise = scl & ~prev_scl;
   wire scl_fall = ~scl & prev_scl;
   wire start_ev = scl & prev_scl & prev_sda & ~sda;
   wire stop_ev = scl & prev_scl & ~prev_sda & sda;
   wire addr_hit = addr_q[7:1] == {FIXED_ADDRESS_BITS, address_strap_input};
   wire is_read = addr_q[0];

   // Line history, idle high
   always_ff @(posedge clk) begin
      prev_scl <= nrst ? scl : 1'b1;
      prev_sda <= nrst ? sda : 1'b1;
   end

   // Frame spans start to stop
   always_ff @(posedge clk) begin
      if (!nrst || stop_ev) in_frame <= 1'b0;
      else if (start_ev) in_frame <= 1'b1;
   end

   // Bit slot in byte; the fall closing the start wraps F to 0
   always_ff @(posedge clk) begin
      if (!nrst || start_ev) begin
         idx <= 4'hF;
         byte_n <= 2'h0;
      end else if (scl_fall && idx == 4'h8) begin
         idx <= 4'h0;
         byte_n <= byte_n + 2'(byte_n != 2'h3);
      end else if (scl_fall) idx <= idx + 4'h1;
   end

   // Address byte shifted in MSB first on clock rise
   always_ff @(posedge clk) begin
      if (!nrst) addr_q <= 8'h00;
      else if (scl_rise && byte_n == 2'h0 && idx < 4'h8)
         addr_q <= {addr_q[6:0], sda};
   end

   // Cycles since the clock fell, saturating
   always_ff @(posedge clk) begin
      if (!nrst) lo_cnt <= 8'hFF;
      else if (scl_fall) lo_cnt <= 8'h01;
      else if (lo_cnt != 8'hFF) lo_cnt <= lo_cnt + 8'h01;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_low_hold;
      !scl [*8];
   endsequence
   sequence s_addr_ack_slot;
      scl && prev_scl && in_frame && byte_n == 2'h0 && idx == 4'h8;
   endsequence

   dev_open_drain_a: assert property (sda_dev_o == 1'b0)
      else $error("slave drives data line high");
   // Address bits and write data: the slave only listens
   dev_listen_a: assert property (scl && in_frame && idx < 4'h8 &&
      (byte_n == 2'h0 || !is_read) |-> !sda_dev_oe)
      else $error("slave pulls data while it should listen");
   scl_low_hold_a: assert property ($fell(scl) |=> s_low_hold)
      else $error("clock low phase too short");
   dev_turn_a: assert property ($changed(sda_dev_oe) |->
      !scl && lo_cnt inside {[8'h01:8'h0C]})
      else $error("slave moved data outside early low phase");
   high_fight_a: assert property (scl |-> !(sda_dev_oe && sda_mst_oe))
      else $error("both ends pull data while clock high");
   idle_quiet_a: assert property (!in_frame |-> !sda_dev_oe)
      else $error("slave pulls data outside a frame");
   ack_slot_a: assert property (scl && sda_dev_oe &&
      !(is_read && byte_n != 2'h0) |-> idx == 4'h8)
      else $error("slave pulls data outside the ninth clock");
   read_slot_a: assert property (scl && in_frame && is_read &&
      byte_n != 2'h0 && idx == 4'h8 |-> !sda_dev_oe)
      else $error("slave holds acknowledge slot on read");
   addr_ack_a: assert property (s_addr_ack_slot |->
      sda_dev_oe == addr_hit)
      else $error("address acknowledge wrong");
   ignore_bus_a: assert property (in_frame && byte_n != 2'h0 &&
      !addr_hit |-> !sda_dev_oe)
      else $error("slave active after foreign address");
   cover_read_c: cover property (in_frame && is_read && byte_n == 2'h1);
endmodule : pwb_checker

// File: verification/port_pwm_blink_twowire_slave_tb.sv
// Bench joining master and slave ends, with a register and pointer model.
// Assumes the host register map and bus timing of the design package.
`timescale 1ns/1ps
module port_pwm_blink_twowire_slave_tb
   import pwb_pkg::*;
;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic ext_sel = 1'b0;
   logic ext_tb = 1'b0;
   logic [2:0] tb_cnt = 3'h0;
   logic [1:0] strap = 2'h0;
   logic [2:0] h_addr = 3'h0;
   logic [7:0] h_wdata = 8'h00;
   logic h_wr = 1'b0;
   logic h_rd = 1'b0;
   logic [7:0] h_rdata;
   logic [NUM_PORTS-1:0] port_out;
   logic [6:0] dev_addr;
   int bad_count = 0;
   int num_checks = 0;
   int m_reg [256];
   int m_ptr = 0;

   pwb_if bus_if ();

   // Clock; the external timebase is clk/8, well below the sync limit
   always #25 clk = ~clk;
   always @(posedge clk) begin
      tb_cnt <= tb_cnt + 3'h1;
      ext_tb <= tb_cnt[2];
   end

   pwb_host pwb_host_inst (.clk(clk), .nrst(nrst), .ce(ce),
      .addr(h_addr), .wdata(h_wdata), .wr(h_wr), .rd(h_rd),
      .rdata(h_rdata), .bus(bus_if.mst));
   pwb_device pwb_device_inst (.clk(clk), .nrst(nrst), .ce(ce),
      .ext_timebase_sel(ext_sel), .external_timebase_input(ext_tb),
      .address_strap_input(strap), .bus(bus_if.dev),
      .port_out(port_out));
   pwb_checker checker_inst (.clk(clk), .nrst(nrst), .scl(bus_if.scl),
      .sda(bus_if.sda), .sda_mst_o(bus_if.sda_mst_o),
      .sda_mst_oe(bus_if.sda_mst_oe), .sda_dev_o(bus_if.sda_dev_o),
      .sda_dev_oe(bus_if.sda_dev_oe), .address_strap_input(strap));

   function automatic bit mapped(int a);
      return (a >= REG_PORT0 && a < REG_PORT0 + NUM_PORTS) || a == REG_CFG;
   endfunction : mapped

   task automatic check(input logic [31:0] got, input int exp_v);
      num_checks++;
      if (got !== 32'(exp_v)) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp_v);
      end
   endtask : check

   // One-cycle strobes, launched right after a rising edge
   task automatic hw(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      h_addr <= a;
      h_wdata <= d;
      h_wr <= 1'b1;
      @(posedge clk);
      h_wr <= 1'b0;
   endtask : hw

   task automatic hr(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      h_addr <= a;
      h_rd <= 1'b1;
      @(posedge clk);
      h_rd <= 1'b0;
      #1;
      d = h_rdata;
   endtask : hr

   // Load a command, clear the sticky nack, go, then poll busy (bounded)
   task automatic run(input logic [6:0] sa, input int ctl, input int p,
      input int d, output logic [7:0] st);
      hw(H_SADDR, 8'(sa));
      hw(H_PTR, 8'(p));
      hw(H_WDATA, 8'(d));
      hw(H_STAT, 8'h02);
      hw(H_CTRL, 8'(ctl));
      st = 8'h01;
      for (int n = 0; n < 5000 && st[S_BUSY] !== 1'b0; n++) hr(H_STAT, st);
      // A command still busy after the poll limit is a hang
      check(st[S_BUSY], 0);
   endtask : run

   task automatic wr_dev(input int p, input int d, input bit with_d);
      logic [7:0] st;
      run(dev_addr, (1 << C_GO) | (int'(with_d) << C_DATA), p, d,
         st);
      check(st[S_NACK], 0);
      m_ptr = p;
      if (with_d && mapped(p)) m_reg[p] = d;
      if (with_d) m_ptr = (p + 1) % 256;
   endtask : wr_dev

   task automatic rd_dev();
      logic [7:0] st;
      logic [7:0] d;
      run(dev_addr, (1 << C_GO) | (1 << C_READ), m_ptr, 0, st);
      hr(H_RDATA, d);
      check(d, mapped(m_ptr) ? m_reg[m_ptr] : 0);
      m_ptr = (m_ptr + 1) % 256;
   endtask : rd_dev

   // High-cycle count of one port, sampled mid-cycle
   task automatic meas(input int port, input int cyc, output int hi);
      hi = 0;
      repeat (cyc) begin
         @(negedge clk);
         if (port_out[port] === 1'b1) hi++;
         else if (port_out[port] !== 1'b0) hi += 100000; // Unknown poisons
      end
   endtask : meas

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up

   // Watchdog past the expected run of about 80k cycles
   initial begin
      repeat (100000) @(posedge clk);
      bad_count++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      wrap_up();
   end

   initial begin
      int d0;
      int b;
      int hv;
      int hi;
      logic [7:0] st;
      void'($urandom(32'h954b));
      strap = 2'($urandom);
      d0 = 1 + $urandom % 31;
      b = 1 + $urandom % 15;
      hv = 8'h70 | ($urandom % 16);
      foreach (m_reg[i]) m_reg[i] = 0;
      dev_addr = {FIXED_ADDRESS_BITS, strap};
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      // Program PWM, static high, fast blink; pointer ends at port 3
      wr_dev(REG_PORT0, d0, 1'b1);
      wr_dev(REG_PORT0 + 1, hv, 1'b1);
      wr_dev(REG_CFG, 8'h1C, 1'b1);
      wr_dev(REG_PORT0 + 2, 8'h20 | b, 1'b1);
      rd_dev();
      rd_dev();
      // Pointer-only write, then two reads walking forward
      wr_dev(REG_PORT0, 0, 1'b0);
      rd_dev();
      rd_dev();
      // Complemented strap address: refused, no register or pointer change
      run({FIXED_ADDRESS_BITS, ~strap}, (1 << C_GO) | (1 << C_DATA),
         REG_PORT0, 8'hFF, st);
      check(st[S_NACK], 1);
      rd_dev();
      // Output timing on the internal timebase, then the external one
      meas(0, 32 * INT_TB_DIV, hi);
      check(hi, d0 * INT_TB_DIV);
      meas(1, 640, hi);
      check(hi, 640);
      @(posedge clk);
      ext_sel <= 1'b1;
      repeat (64) @(posedge clk);
      meas(0, 32 * 8, hi);
      check(hi, d0 * 8);
      meas(2, 1024 * 8, hi);
      check(hi, b * 1024 * 8 / 16);
      meas(3, 256, hi);
      check(hi, 0);
      // Enable low freezes every flop, so the PWM pin cannot move
      @(posedge clk);
      ce <= 1'b0;
      meas(0, 256, hi);
      check(hi % 256, 0);
      @(posedge clk);
      ce <= 1'b1;
      repeat (64) @(posedge clk);
      meas(0, 32 * 8, hi);
      check(hi, d0 * 8);
      wrap_up();
   end
endmodule : port_pwm_blink_twowire_slave_tb
